/* File: src/dcb_regs.svh */
`ifndef DCB_REGS_SVH
`define DCB_REGS_SVH
// opcodes of byte 0
`define DCB_OP_FMT_DRIVE 8'h04
`define DCB_OP_CHECK 8'h05
`define DCB_OP_FMT_TRACK 8'h06
`define DCB_OP_FMT_BAD 8'h07
`define DCB_OP_READ 8'h08
`define DCB_OP_VERIFY 8'h09
`define DCB_OP_WRITE 8'h0A
`define DCB_OP_SEEK 8'h0B
// field positions
`define DCB_DRIVE_BIT 5
`define DCB_RETRY_OFF_BIT 7
`define DCB_ECC_OPT_BIT 6
`define DCB_PATTERN_BIT 5
`define DCB_SERVO_BIT 4
// error codes
`define DCB_ERR_NONE 8'h00
`define DCB_ERR_ID 8'h10
`define DCB_ERR_UNCORR 8'h11
`define DCB_ERR_CORR 8'h18
`define DCB_ERR_FORMAT 8'h1A
`define DCB_ERR_BAD_CMD 8'h20
`define DCB_ERR_BAD_PARAM 8'h22
// constants and reset values
`define DCB_FILL_DEFAULT 8'h6C
`define DCB_IL_MAX_256 5'h1F
`define DCB_IL_MAX_512 5'h10
`define DCB_STEP_UNBUFFERED 4'h0
`define DCB_CMD_LAST 3'h5
`define DCB_BLOCKS_MAX 9'h100
`endif

/* File: src/dcb_pkg.sv */
`default_nettype none
package dcb_pkg;
	typedef enum logic [3:0] {
		S_IDLE, S_CMD, S_DECODE, S_TBL, S_TRK_PREP, S_TRK_ISSUE,
		S_XFER, S_HOST_IN, S_HOST_OUT, S_WAIT
	} state_t;
	typedef enum logic [2:0] {
		OP_NONE, OP_RECAL, OP_SEEK, OP_READ_ID, OP_FMT_SECTOR, OP_READ_DATA, OP_WRITE_DATA
	} op_t;
	typedef enum logic [2:0] {
		DRV_OK, DRV_ID_ERR, DRV_DATA_CORR, DRV_DATA_UNCORR, DRV_FAULT
	} drv_status_t;
	typedef struct packed {
		logic [15:0] cyl;
		logic [3:0] head;
		logic [4:0] sec;
	} chs_t;
	typedef struct packed {
		state_t st;
		state_t ret;
		logic [2:0] idx;
		logic [5:0][7:0] cmd;
		chs_t c;
		logic [8:0] remain;
		logic [5:0] k;
		logic [5:0] n;
		logic [4:0] pos;
		logic [31:0] used;
		logic retried;
		logic [7:0] pend;
		op_t op;
		logic host_req;
		logic done;
		logic [7:0] err;
		logic settle;
	} exec_t;
endpackage
`default_nettype wire

/* File: src/itab_if.sv */
`default_nettype none
interface itab_if;
	logic we;
	logic [4:0] waddr;
	logic [4:0] wdata;
	logic [4:0] raddr;
	logic [4:0] rdata;
	modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

/* File: src/interleave_table.sv */
`default_nettype none
// one entry per physical sector slot: the logical sector number placed there
module interleave_table (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// table port
	itab_if.mem tbl
);
	logic [4:0] mem_q [32];
	logic [4:0] rdata_q;

	// storage has no reset; only slots written by the builder are ever read
	always_ff @(posedge i_ref_clk) begin
		if (tbl.we) begin
			mem_q[tbl.waddr] <= tbl.wdata;
		end
	end

	// registered read, one cycle after the address
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			rdata_q <= 5'h00;
		end else begin
			rdata_q <= mem_q[tbl.raddr];
		end
	end

	assign tbl.rdata = rdata_q;
endmodule
`default_nettype wire

/* File: src/disk_command_block_executor.sv */
`include "dcb_regs.svh"
`default_nettype none
//Contract
//- format pattern: 6C when control bit 5 clear, loaded buffer when set
//- control bit 4 chooses normal or embedded-servo track format
//- interleave 1..31 for 256-byte sectors, 1..16 for 512-byte sectors
//- check track builds interleave table, seeks without recalibrate, reads sectors 0..last
//- bad ID or sector mismatch in check reports code 1A
//- check track reads ID fields only, never data fields
//- format track recalibrates, seeks, writes ID and data with interleave; code issues recalibrate only, no seek before formatting
//- format track clears defective and alternate flags in IDs
//- format bad track sets bad flag in every ID, writes no data
//- block layout: opcode, drive bit, 21-bit address, count, control byte
//- read moves 1 to 256 sectors per block count
//- linear sector address converts to cylinder, head, sector
//- multi-sector transfer stops at unrecoverable error and records it
//- reported correctable sector still goes to host before ending
//- other errors: failing sector data is not delivered
//- read reports correctable errors only when ECC option bit is one
//- read verify checks media like read but sends no data
//- verify with ECC bit zero retries once, reports only if retry fails
//- verify with ECC bit one never retries, reports every ECC error
//- write moves 1 to 256 sectors, produces no ECC errors
//- buffered seek completes after step pulses, before drive settles
//- corrected data error reports code 18
//- unsupported opcode rejected with code 20
module disk_command_block_executor (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// command bytes from the host bus side
	input wire logic i_cmd_valid,
	input wire logic [7:0] i_cmd_byte,
	output logic o_cmd_ready,
	output logic o_cmd_done,
	output logic [7:0] o_error_code,
	// drive configuration
	input wire logic [5:0] i_sectors_per_track,
	input wire logic [4:0] i_heads,
	input wire logic i_sector_512,
	// drive sequencer
	output logic o_drv_req,
	output dcb_pkg::op_t o_drv_op,
	output logic o_drv_select,
	output logic [15:0] o_drv_cyl,
	output logic [3:0] o_drv_head,
	output logic [4:0] o_drv_sector,
	output logic [3:0] o_drv_step,
	output logic o_drv_no_retry,
	output logic o_drv_wait_settle,
	output logic o_drv_servo_fmt,
	output logic o_drv_write_data,
	output logic [1:0] o_drv_id_flags,
	output logic o_fill_use_buffer,
	output logic [7:0] o_fill_byte,
	input wire logic i_drv_done,
	input wire dcb_pkg::drv_status_t i_drv_status,
	input wire logic [4:0] i_drv_id_sector,
	input wire logic [7:0] i_drv_err_code,
	// sector data moves with the host
	output logic o_host_req,
	input wire logic i_host_done
);
	dcb_pkg::exec_t q, d;
	itab_if tbl ();
	logic [7:0] opc;
	logic [4:0] il;
	logic fmt_op, check_op, trk_op, il_bad, ecc_opt;

	interleave_table u_interleave_table (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.tbl(tbl)
	);

	function automatic logic [4:0] mod_add(logic [4:0] a, logic [5:0] b, logic [5:0] m);
		logic [6:0] s;
		s = {2'b00, a} + {1'b0, b};
		return 5'(s % {1'b0, m});
	endfunction

	function automatic dcb_pkg::chs_t lin_to_chs(logic [20:0] lba, logic [5:0] spt,
			logic [4:0] hd);
		logic [20:0] trk;
		dcb_pkg::chs_t c;
		trk = lba / {15'h0000, spt};
		c.sec = 5'(lba % {15'h0000, spt});
		c.head = 4'(trk % {16'h0000, hd});
		c.cyl = 16'(trk / {16'h0000, hd});
		return c;
	endfunction

	function automatic dcb_pkg::chs_t next_chs(dcb_pkg::chs_t c, logic [5:0] spt,
			logic [4:0] hd);
		dcb_pkg::chs_t r;
		r = c;
		if ({1'b0, c.sec} + 6'h01 < spt) begin
			r.sec = c.sec + 5'h01;
		end else begin
			r.sec = 5'h00;
			if ({1'b0, c.head} + 5'h01 < hd) begin
				r.head = c.head + 4'h1;
			end else begin
				r.head = 4'h0;
				r.cyl = c.cyl + 16'h0001;
			end
		end
		return r;
	endfunction

	// decoded fields of the stored block
	always_comb begin
		opc = q.cmd[0];
		il = q.cmd[4][4:0];
		check_op = (opc == `DCB_OP_CHECK);
		fmt_op = (opc == `DCB_OP_FMT_DRIVE) || (opc == `DCB_OP_FMT_TRACK)
			|| (opc == `DCB_OP_FMT_BAD);
		trk_op = check_op || fmt_op;
		il_bad = (q.cmd[4][7:5] != 3'h0) || (il == 5'h00)
			|| (il > (i_sector_512 ? `DCB_IL_MAX_512 : `DCB_IL_MAX_256));
		ecc_opt = q.cmd[5][`DCB_ECC_OPT_BIT];
	end

	// table builder writes while searching for free slots
	always_comb begin
		tbl.we = (q.st == dcb_pkg::S_TBL) && (q.n != i_sectors_per_track) && !q.used[q.pos];
		tbl.waddr = q.pos;
		tbl.wdata = q.n[4:0];
		tbl.raddr = q.k[4:0];
	end

	// next-state logic of the whole executor
	always_comb begin
		d = q;
		d.done = 1'b0;
		unique case (q.st)
			dcb_pkg::S_IDLE, dcb_pkg::S_CMD: begin
				if (i_cmd_valid) begin
					d.cmd[q.idx] = i_cmd_byte;
					d.idx = q.idx + 3'h1;
					d.st = (q.idx == `DCB_CMD_LAST) ? dcb_pkg::S_DECODE : dcb_pkg::S_CMD;
				end
			end
			dcb_pkg::S_DECODE: begin
				d.idx = 3'h0;
				d.c = lin_to_chs({q.cmd[1][4:0], q.cmd[2], q.cmd[3]},
					i_sectors_per_track, i_heads);
				d.remain = (q.cmd[4] == 8'h00) ? `DCB_BLOCKS_MAX : {1'b0, q.cmd[4]};
				d.retried = 1'b0;
				d.pend = `DCB_ERR_NONE;
				d.n = 6'h00;
				d.k = 6'h00;
				d.pos = 5'h00;
				d.used = 32'h0000_0000;
				d.settle = 1'b1;
				if (trk_op && il_bad) begin
					d.err = `DCB_ERR_BAD_PARAM;
					d.done = 1'b1;
					d.st = dcb_pkg::S_IDLE;
				end else if (trk_op) begin
					d.st = dcb_pkg::S_TBL;
				end else if (opc == `DCB_OP_READ || opc == `DCB_OP_VERIFY
						|| opc == `DCB_OP_WRITE) begin
					d.op = dcb_pkg::OP_SEEK;
					d.ret = dcb_pkg::S_XFER;
					d.st = dcb_pkg::S_WAIT;
				end else if (opc == `DCB_OP_SEEK) begin
					// buffered stepping ends the command once the pulses are out
					d.settle = (q.cmd[5][3:0] == `DCB_STEP_UNBUFFERED);
					d.op = dcb_pkg::OP_SEEK;
					d.ret = dcb_pkg::S_IDLE;
					d.st = dcb_pkg::S_WAIT;
				end else begin
					d.err = `DCB_ERR_BAD_CMD;
					d.done = 1'b1;
					d.st = dcb_pkg::S_IDLE;
				end
			end
			dcb_pkg::S_TBL: begin
				if (q.n == i_sectors_per_track) begin
					d.c.sec = 5'h00;
					d.ret = dcb_pkg::S_TRK_PREP;
					d.op = check_op ? dcb_pkg::OP_SEEK : dcb_pkg::OP_RECAL;
					d.st = dcb_pkg::S_WAIT;
				end else if (q.used[q.pos]) begin
					d.pos = mod_add(q.pos, 6'h01, i_sectors_per_track);
				end else begin
					d.used[q.pos] = 1'b1;
					d.n = q.n + 6'h01;
					d.pos = mod_add(q.pos, {1'b0, il}, i_sectors_per_track);
				end
			end
			dcb_pkg::S_TRK_PREP: begin
				d.st = dcb_pkg::S_TRK_ISSUE; // table read settles here
			end
			dcb_pkg::S_TRK_ISSUE: begin
				if (q.k == i_sectors_per_track) begin
					d.err = `DCB_ERR_NONE;
					d.done = 1'b1;
					d.st = dcb_pkg::S_IDLE;
				end else begin
					d.c.sec = tbl.rdata;
					d.op = check_op ? dcb_pkg::OP_READ_ID : dcb_pkg::OP_FMT_SECTOR;
					d.ret = dcb_pkg::S_TRK_PREP;
					d.st = dcb_pkg::S_WAIT;
				end
			end
			dcb_pkg::S_XFER: begin
				if (q.remain == 9'h000 || q.pend != `DCB_ERR_NONE) begin
					d.err = q.pend;
					d.done = 1'b1;
					d.st = dcb_pkg::S_IDLE;
				end else if (opc == `DCB_OP_WRITE) begin
					d.host_req = 1'b1;
					d.st = dcb_pkg::S_HOST_IN;
				end else begin
					d.op = dcb_pkg::OP_READ_DATA;
					d.st = dcb_pkg::S_WAIT;
				end
			end
			dcb_pkg::S_HOST_IN: begin
				if (i_host_done) begin
					d.host_req = 1'b0;
					d.op = dcb_pkg::OP_WRITE_DATA;
					d.st = dcb_pkg::S_WAIT;
				end
			end
			dcb_pkg::S_HOST_OUT: begin
				if (i_host_done) begin
					d.host_req = 1'b0;
					d.remain = q.remain - 9'h001;
					d.c = next_chs(q.c, i_sectors_per_track, i_heads);
					d.st = dcb_pkg::S_XFER; // pending error ends it there
				end
			end
			dcb_pkg::S_WAIT: begin
				if (i_drv_done) begin
					d.op = dcb_pkg::OP_NONE;
					d.st = q.ret;
					d.err = `DCB_ERR_NONE;
					if (i_drv_status == dcb_pkg::DRV_OK) begin
						if (q.op == dcb_pkg::OP_READ_ID && i_drv_id_sector != q.c.sec) begin
							d.err = `DCB_ERR_FORMAT;
							d.done = 1'b1;
							d.st = dcb_pkg::S_IDLE;
						end else if (q.op == dcb_pkg::OP_READ_ID
								|| q.op == dcb_pkg::OP_FMT_SECTOR) begin
							d.k = q.k + 6'h01;
						end else if (q.op == dcb_pkg::OP_READ_DATA
								|| q.op == dcb_pkg::OP_WRITE_DATA) begin
							d.retried = 1'b0;
							if (opc == `DCB_OP_READ) begin
								d.host_req = 1'b1;
								d.st = dcb_pkg::S_HOST_OUT;
							end else begin
								d.remain = q.remain - 9'h001;
								d.c = next_chs(q.c, i_sectors_per_track, i_heads);
								d.st = dcb_pkg::S_XFER;
							end
						end else if (q.ret == dcb_pkg::S_IDLE) begin
							d.done = 1'b1; // seek finished
						end
					end else if (q.op == dcb_pkg::OP_READ_DATA
							&& (i_drv_status == dcb_pkg::DRV_DATA_CORR
							|| i_drv_status == dcb_pkg::DRV_DATA_UNCORR)
							&& opc == `DCB_OP_VERIFY && !ecc_opt && !q.retried) begin
						// request drops for a cycle so the drive sees a fresh op
						d.retried = 1'b1;
						d.st = dcb_pkg::S_XFER;
					end else if (q.op == dcb_pkg::OP_READ_DATA
							&& i_drv_status == dcb_pkg::DRV_DATA_CORR) begin
						if (opc == `DCB_OP_READ) begin
							// corrected sector still goes out first
							d.pend = ecc_opt ? `DCB_ERR_CORR : `DCB_ERR_NONE;
							d.host_req = 1'b1;
							d.st = dcb_pkg::S_HOST_OUT;
						end else begin
							d.err = `DCB_ERR_CORR;
							d.done = 1'b1;
							d.st = dcb_pkg::S_IDLE;
						end
					end else begin
						// failing sector is dropped, its error kept for sense
						if (q.op == dcb_pkg::OP_READ_ID) begin
							d.err = `DCB_ERR_FORMAT;
						end else if (i_drv_status == dcb_pkg::DRV_ID_ERR) begin
							d.err = `DCB_ERR_ID;
						end else if (i_drv_status == dcb_pkg::DRV_DATA_UNCORR) begin
							d.err = `DCB_ERR_UNCORR;
						end else begin
							d.err = i_drv_err_code;
						end
						d.done = 1'b1;
						d.st = dcb_pkg::S_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ready and drive request straight from state; done, host request and data from registers
	assign o_cmd_ready = (q.st == dcb_pkg::S_IDLE) || (q.st == dcb_pkg::S_CMD);
	assign o_cmd_done = q.done;
	assign o_error_code = q.err;
	assign o_drv_req = (q.st == dcb_pkg::S_WAIT);
	assign o_drv_op = q.op;
	assign o_drv_select = q.cmd[1][`DCB_DRIVE_BIT];
	assign o_drv_cyl = q.c.cyl;
	assign o_drv_head = q.c.head;
	assign o_drv_sector = q.c.sec;
	assign o_drv_step = q.cmd[5][3:0];
	assign o_drv_no_retry = q.cmd[5][`DCB_RETRY_OFF_BIT];
	assign o_drv_wait_settle = q.settle;
	assign o_drv_servo_fmt = fmt_op && q.cmd[5][`DCB_SERVO_BIT];
	assign o_drv_write_data = (opc != `DCB_OP_FMT_BAD);
	// bit 1 bad-track flag, bit 0 alternate flag; reformat never sets alternate
	assign o_drv_id_flags = {opc == `DCB_OP_FMT_BAD, 1'b0};
	assign o_fill_use_buffer = q.cmd[5][`DCB_PATTERN_BIT];
	assign o_fill_byte = `DCB_FILL_DEFAULT;
	assign o_host_req = q.host_req;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);

	sequence s_uncorr_read;
		o_drv_req && i_drv_done && o_drv_op == dcb_pkg::OP_READ_DATA
			&& i_drv_status == dcb_pkg::DRV_DATA_UNCORR && opc == `DCB_OP_READ;
	endsequence
	sequence s_corr_read;
		o_drv_req && i_drv_done && o_drv_op == dcb_pkg::OP_READ_DATA
			&& i_drv_status == dcb_pkg::DRV_DATA_CORR && opc == `DCB_OP_READ;
	endsequence

	property p_bad_opcode;
		q.st == dcb_pkg::S_DECODE && !trk_op && opc < `DCB_OP_READ |=> o_cmd_done
			&& o_error_code == `DCB_ERR_BAD_CMD;
	endproperty
	a_bad_opcode: assert property (p_bad_opcode) else $error("bad opcode not rejected");
	property p_il_reject;
		q.st == dcb_pkg::S_DECODE && trk_op && il_bad |=> o_cmd_done
			&& o_error_code == `DCB_ERR_BAD_PARAM && !o_drv_req;
	endproperty
	a_il_reject: assert property (p_il_reject) else $error("bad interleave ran");
	property p_check_id_only;
		o_drv_req && check_op |-> o_drv_op inside {dcb_pkg::OP_SEEK, dcb_pkg::OP_READ_ID};
	endproperty
	a_check_id_only: assert property (p_check_id_only) else $error("check touched data");
	property p_fmt_bad;
		o_drv_req && o_drv_op == dcb_pkg::OP_FMT_SECTOR && opc == `DCB_OP_FMT_BAD
			|-> o_drv_id_flags == 2'b10 && !o_drv_write_data;
	endproperty
	a_fmt_bad: assert property (p_fmt_bad) else $error("bad track format wrong");
	property p_fmt_pattern;
		o_drv_req && o_drv_op == dcb_pkg::OP_FMT_SECTOR |-> o_fill_byte == 8'h6C
			&& o_fill_use_buffer == q.cmd[5][5] && o_drv_servo_fmt == q.cmd[5][4];
	endproperty
	a_fmt_pattern: assert property (p_fmt_pattern) else $error("fill or servo wrong");
	property p_verify_silent;
		opc == `DCB_OP_VERIFY && q.st != dcb_pkg::S_CMD |-> !o_host_req;
	endproperty
	a_verify_silent: assert property (p_verify_silent) else $error("verify sent data");
	property p_uncorr_stop;
		s_uncorr_read |=> o_cmd_done && o_error_code == `DCB_ERR_UNCORR && !o_host_req;
	endproperty
	a_uncorr_stop: assert property (p_uncorr_stop) else $error("failed sector sent");
	property p_corr_deliver;
		s_corr_read |=> o_host_req;
	endproperty
	a_corr_deliver: assert property (p_corr_deliver) else $error("corrected sector lost");
	property p_check_mismatch;
		o_drv_req && i_drv_done && o_drv_op == dcb_pkg::OP_READ_ID
			&& i_drv_status == dcb_pkg::DRV_OK && i_drv_id_sector != o_drv_sector
			|=> o_cmd_done && o_error_code == `DCB_ERR_FORMAT;
	endproperty
	a_check_mismatch: assert property (p_check_mismatch) else $error("mismatch missed");
endmodule
`default_nettype wire

/* File: dv/drive_model.sv */
`default_nettype none
// drive sequencer stand-in: answers each op after a latency and keeps written ids per slot
module drive_model (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// op from the executor
	input wire logic i_req,
	input wire dcb_pkg::op_t i_op,
	input wire logic [4:0] i_sector,
	// fault plan from the bench
	input wire logic [7:0] i_lat,
	input wire logic [8:0] i_inj_at,
	input wire logic [8:0] i_inj_len,
	input wire dcb_pkg::drv_status_t i_inj_st,
	// answer
	output logic o_done,
	output dcb_pkg::drv_status_t o_status,
	output logic [4:0] o_id_sector,
	output logic [7:0] o_err_code
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] ids [32];
	logic [1:0] ph;
	logic [7:0] cnt;
	int slot;
	int dn;
	// falling edge drive; answer lines wander between answers so stale values never match
	always @(negedge i_ref_clk) begin
		o_done <= 1'b0;
		o_id_sector <= ~o_id_sector;
		o_err_code <= ~o_err_code;
		o_status <= (o_status == dcb_pkg::DRV_FAULT) ? dcb_pkg::DRV_ID_ERR : dcb_pkg::DRV_FAULT;
		if (!i_resetn) begin
			ph <= 2'h0;
			slot <= 0;
			dn <= 0;
			o_id_sector <= 5'h00;
			o_err_code <= 8'h00;
			o_status <= dcb_pkg::DRV_OK;
		end else if (ph == 2'h0 && i_req) begin
			ph <= 2'h1;
			cnt <= i_lat;
		end else if (ph == 2'h1 && cnt != 8'h00) begin
			cnt <= cnt - 8'h01;
		end else if (ph == 2'h1) begin
			ph <= 2'h2;
			o_done <= 1'b1;
			o_status <= dcb_pkg::DRV_OK;
			o_err_code <= 8'h00;
			case (i_op)
				dcb_pkg::OP_RECAL, dcb_pkg::OP_SEEK: begin
					slot <= 0;
					dn <= 0;
				end
				dcb_pkg::OP_FMT_SECTOR: begin
					ids[slot] <= i_sector;
					slot <= slot + 1;
				end
				dcb_pkg::OP_READ_ID: begin
					o_id_sector <= ids[slot];
					slot <= slot + 1;
				end
				default: begin
					dn <= dn + 1;
					if (dn >= i_inj_at && dn < i_inj_at + i_inj_len) o_status <= i_inj_st;
				end
			endcase
		end else if (ph == 2'h2 && !i_req) begin
			ph <= 2'h0;
		end
	end
endmodule
`default_nettype wire

/* File: dv/disk_command_block_executor_bench.sv */
`default_nettype none
// host side driven here, drive model on the far side
module disk_command_block_executor_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_ref_clk = 1'b0, i_resetn = 1'b0, i_cmd_valid = 1'b0, i_host_done = 1'b0;
	logic i_sector_512 = 1'b0, req_q = 1'b0, hbusy = 1'b0, i_drv_done;
	logic [7:0] i_cmd_byte = 8'h00, lat = 8'h00, o_error_code, o_fill_byte, i_drv_err_code, code;
	logic [5:0] i_sectors_per_track = 6'h08;
	logic [4:0] i_heads = 5'h04, o_drv_sector, i_drv_id_sector;
	logic [15:0] o_drv_cyl;
	logic [3:0] o_drv_head, o_drv_step;
	logic [1:0] o_drv_id_flags;
	logic [8:0] inj_at = 9'h000, inj_len = 9'h000;
	logic o_cmd_ready, o_cmd_done, o_drv_req, o_drv_select, o_drv_no_retry, o_drv_wait_settle;
	logic o_drv_servo_fmt, o_drv_write_data, o_fill_use_buffer, o_host_req;
	logic [31:0] first, fmt, lfsr = 32'hFF3ED4FB;
	logic [20:0] lba;
	dcb_pkg::op_t o_drv_op;
	dcb_pkg::drv_status_t i_drv_status, inj_st = dcb_pkg::DRV_OK;
	dcb_pkg::op_t ops[$];
	logic [4:0] secs[$];
	int n_fail = 0, checked = 0, host_cnt = 0, i, e, h, d, r, il;
	int tbl[8];
	logic [7:0] bad_op[4] = '{8'h00, 8'h03, 8'h0C, 8'hFF};
	logic [7:0] rej_il[3] = '{8'h00, 8'h20, 8'h11};
	int c_op[10] = '{8, 8, 8, 8, 8, 9, 9, 9, 10, 8};
	int c_n[10] = '{3, 0, 5, 5, 5, 4, 4, 4, 4, 4};
	int c_f[10] = '{0, 0, 2, 2, 2, 1, 1, 1, 0, 1};
	int c_len[10] = '{0, 0, 1, 1, 1, 1, 2, 1, 0, 1};
	int c_st[10] = '{0, 0, 3, 2, 2, 2, 3, 2, 0, 1};
	int c_a[10] = '{0, 0, 0, 1, 0, 0, 0, 1, 0, 0};

	disk_command_block_executor u_disk_command_block_executor (
		.i_ref_clk, .i_resetn, .i_cmd_valid, .i_cmd_byte, .o_cmd_ready, .o_cmd_done,
		.o_error_code, .i_sectors_per_track, .i_heads, .i_sector_512, .o_drv_req, .o_drv_op,
		.o_drv_select, .o_drv_cyl, .o_drv_head, .o_drv_sector, .o_drv_step, .o_drv_no_retry,
		.o_drv_wait_settle, .o_drv_servo_fmt, .o_drv_write_data, .o_drv_id_flags,
		.o_fill_use_buffer, .o_fill_byte, .i_drv_done, .i_drv_status, .i_drv_id_sector,
		.i_drv_err_code, .o_host_req, .i_host_done
	);
	drive_model u_drive_model (
		.i_ref_clk, .i_resetn, .i_req(o_drv_req), .i_op(o_drv_op), .i_sector(o_drv_sector),
		.i_lat(lat), .i_inj_at(inj_at), .i_inj_len(inj_len), .i_inj_st(inj_st),
		.o_done(i_drv_done), .o_status(i_drv_status), .o_id_sector(i_drv_id_sector),
		.o_err_code(i_drv_err_code)
	);

	always #10 i_ref_clk = ~i_ref_clk;

	// log ops as presented and answer each host sector once; falling edge avoids races
	always @(negedge i_ref_clk) begin
		req_q <= o_drv_req;
		if (o_drv_req && !req_q) begin
			if (ops.size() == 0) first <= {o_drv_cyl, o_drv_head, o_drv_sector, o_drv_select,
				o_drv_no_retry, o_drv_step, o_drv_wait_settle};
			if (o_drv_op == dcb_pkg::OP_FMT_SECTOR) begin
				secs.push_back(o_drv_sector);
				fmt <= {19'h00000, o_drv_servo_fmt, o_drv_write_data, o_drv_id_flags,
					o_fill_use_buffer, o_fill_byte};
			end
			ops.push_back(o_drv_op);
		end
		if (i_host_done) i_host_done <= 1'b0;
		else if (o_host_req && !hbusy) begin
			i_host_done <= 1'b1;
			hbusy <= 1'b1;
			host_cnt <= host_cnt + 1;
		end else if (!o_host_req) hbusy <= 1'b0;
	end

	function automatic logic [31:0] nxt(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic int cnt(input dcb_pkg::op_t k);
		int c = 0;
		foreach (ops[j]) if (ops[j] == k) c++;
		return c;
	endfunction

	// slot to logical sector map, placed at pos and skipping used slots
	task automatic mk_tbl(input int ilv);
		int n, p;
		bit used[8];
		p = 0;
		for (n = 0; n < 8; n++) begin
			while (used[p]) p = (p + 1) % 8;
			tbl[p] = n;
			used[p] = 1'b1;
			p = (p + ilv) % 8;
		end
	endtask

	// reference transfer: error code, sectors to host, media data ops
	task automatic model(input int op, nn, f, len, st, a, output int ec, hc, dc);
		int s, b;
		ec = 0;
		hc = 0;
		dc = 0;
		for (s = 0; s < nn && ec == 0; s++) begin
			b = (dc >= f && dc < f + len) ? st : 0;
			dc++;
			if (op == 9 && a == 0 && b > 1) begin
				b = (dc >= f && dc < f + len) ? st : 0;
				dc++;
			end
			if (b == 1) ec = 8'h10;
			else if (b == 3) ec = 8'h11;
			else if (b == 2) begin
				if (op == 8) hc++;
				if (a == 1 || op == 9) ec = 8'h18;
			end else if (op != 9) hc++;
		end
	endtask

	task automatic chk_num(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t mismatch got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic chk_code(input logic [7:0] got, input logic [7:0] exp);
		chk_num({24'h000000, got}, {24'h000000, exp});
	endtask

	// six bytes while ready, then a bounded wait for done; a missing done gives code FF
	task automatic run_cmd(input logic [47:0] blk);
		int k;
		ops.delete();
		secs.delete();
		host_cnt = 0;
		for (k = 0; k < 6; k++) begin
			@(negedge i_ref_clk);
			i_cmd_valid = 1'b1;
			i_cmd_byte = blk[47 - 8 * k -: 8];
			while (o_cmd_ready !== 1'b1) @(negedge i_ref_clk);
		end
		@(negedge i_ref_clk);
		i_cmd_valid = 1'b0;
		for (k = 0; k < 20000; k++) begin
			@(posedge i_ref_clk);
			#1;
			if (o_cmd_done === 1'b1) break;
		end
		code = (o_cmd_done === 1'b1) ? o_error_code : 8'hFF;
	endtask

	task automatic report_and_stop();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// hang guard, far beyond the longest expected run
	initial begin
		repeat (60000) @(posedge i_ref_clk);
		n_fail++;
		report_and_stop();
	end

	initial begin
		repeat (12) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
		i_resetn = 1'b1;
		foreach (bad_op[j]) begin
			run_cmd({bad_op[j], 40'h0000000000});
			chk_code(code, 8'h20);
		end
		foreach (rej_il[j]) begin
			i_sector_512 = (j == 2);
			run_cmd({8'h06, 3'h0, 21'h000040, rej_il[j], 8'h00});
			chk_code(code, 8'h22);
			chk_num(32'(ops.size()), 32'h00000000);
		end
		// widest interleave of each sector size, both fill and drive-type options
		for (i = 0; i < 2; i++) begin
			i_sector_512 = i[0];
			il = i ? 16 : 31;
			mk_tbl(il);
			run_cmd({i ? 8'h04 : 8'h06, 3'h0, 21'h000040, 8'(il), i ? 8'h00 : 8'h35});
			chk_code(code, 8'h00);
			chk_num(32'(ops[0]), 32'(dcb_pkg::OP_RECAL));
			chk_num(32'(cnt(dcb_pkg::OP_FMT_SECTOR)), 32'h00000008);
			foreach (tbl[j]) chk_num(32'(secs[j]), 32'(tbl[j]));
			chk_num(fmt, {19'h00000, ~i[0], 1'b1, 2'h0, ~i[0], 8'h6C});
		end
		run_cmd({8'h05, 3'h0, 21'h000040, 8'h10, 8'h00});
		chk_code(code, 8'h00);
		chk_num({16'(ops[0]), 8'(cnt(dcb_pkg::OP_RECAL)), 8'(cnt(dcb_pkg::OP_READ_DATA))},
			{16'(dcb_pkg::OP_SEEK), 16'h0000});
		chk_num(32'(cnt(dcb_pkg::OP_READ_ID)), 32'h00000008);
		run_cmd({8'h05, 3'h0, 21'h000040, 8'h03, 8'h00});
		chk_code(code, 8'h1A);
		run_cmd({8'h07, 3'h0, 21'h000040, 8'h01, 8'h00});
		chk_code(code, 8'h00);
		chk_num(fmt, {19'h00000, 1'b0, 1'b0, 2'h2, 1'b0, 8'h6C});
		i_sector_512 = 1'b0;
		// transfers with random address, options and drive latency
		for (i = 0; i < 10; i++) begin
			lfsr = nxt(lfsr);
			lba = {1'b0, lfsr[19:0]};
			lat = {4'h0, lfsr[24:21]};
			inj_at = 9'(c_f[i]);
			inj_len = 9'(c_len[i]);
			inj_st = dcb_pkg::drv_status_t'(c_st[i]);
			run_cmd({8'(c_op[i]), 2'h0, lfsr[29], lba, 8'(c_n[i]),
				lfsr[31], c_a[i][0], 2'h0, lfsr[28:25]});
			model(c_op[i], c_n[i] ? c_n[i] : 256, c_f[i], c_len[i], c_st[i], c_a[i], e, h, d);
			chk_code(code, 8'(e));
			chk_num(32'(host_cnt), 32'(h));
			chk_num(32'(cnt(c_op[i] == 10 ? dcb_pkg::OP_WRITE_DATA : dcb_pkg::OP_READ_DATA)),
				32'(d));
			chk_num({first[31:1], 1'b0}, {16'(lba / 32), 4'((lba / 8) % 4), 5'(lba % 8),
				lfsr[29], lfsr[31], lfsr[28:25], 1'b0});
			if (c_op[i] == 8 && e != 0) begin
				inj_len = 9'h000;
				r = c_f[i] + ((c_st[i] == 2) ? 1 : 0);
				run_cmd({8'h08, 3'h0, lba + 21'(r), 8'(c_n[i] - r), 8'h00});
				chk_num(32'(host_cnt), 32'(c_n[i] - r));
			end
		end
		// unbuffered then buffered stepping
		for (i = 0; i < 2; i++) begin
			run_cmd({8'h0B, 3'h0, 21'h000123, 8'h00, 4'h0, 4'(i * 7)});
			chk_code(code, 8'h00);
			chk_num({30'(ops.size()), first[0], 1'b0}, {30'h1, i == 0, 1'b0});
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
